//--- rtl/pakr_pkg.sv
// Package for the pointer authentication key register bank
package pakr_pkg;
   localparam int KeyWidth = 64;
   localparam int NumKeys = 6;
   localparam logic [1:0] Op0Sys = 2'h3;
   localparam logic [2:0] Op1Key = 3'h0;
   localparam logic [3:0] CrnKey = 4'h2;
   localparam logic [3:0] CrmInstrA = 4'h1;
   localparam logic [3:0] CrmDataB = 4'h2;
   localparam logic [3:0] CrmGenericA = 4'h3;
   localparam logic [2:0] Op2AKeyLo = 3'h0;
   localparam logic [2:0] Op2AKeyHi = 3'h1;
   localparam logic [2:0] Op2BKeyLo = 3'h2;
   localparam logic [2:0] Op2BKeyHi = 3'h3;
   localparam logic [1:0] ElUser = 2'h0;
   // Key slot indices
   localparam logic [2:0] IdxDataBHigh = 3'h0;
   localparam logic [2:0] IdxDataBLow = 3'h1;
   localparam logic [2:0] IdxGenericAHigh = 3'h2;
   localparam logic [2:0] IdxGenericALow = 3'h3;
   localparam logic [2:0] IdxInstrAHigh = 3'h4;
   localparam logic [2:0] IdxInstrALow = 3'h5;

   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } pakr_enc_t;

   typedef struct packed {
      logic valid;
      logic isWrite;
      logic [1:0] excLevel;
      pakr_enc_t enc;
      logic [KeyWidth-1:0] wdata;
   } pakr_req_t;

   typedef struct packed {
      logic done;
      logic undef;
      logic [KeyWidth-1:0] rdata;
   } pakr_rsp_t;

   typedef struct packed {
      logic [NumKeys-1:0][KeyWidth-1:0] keys;
      pakr_rsp_t rsp;
   } pakr_state_t;
endpackage

//--- rtl/pakr_key_regs.sv
// Pointer authentication key register bank with system register access
`timescale 1ns/100ps
module pakr_key_regs #(
   parameter bit FeatureEn = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire pakr_pkg::pakr_req_t req,
   output pakr_pkg::pakr_rsp_t rsp
);
   pakr_pkg::pakr_state_t state_r;
   pakr_pkg::pakr_state_t state_nxt;

   // Decode an encoding to a key slot; hit is low for foreign encodings
   function automatic logic [3:0] decode(input pakr_pkg::pakr_enc_t e);
      logic hit;
      logic [2:0] idx;
      hit = (e.op0 == pakr_pkg::Op0Sys) && (e.op1 == pakr_pkg::Op1Key) &&
            (e.crn == pakr_pkg::CrnKey);
      idx = pakr_pkg::IdxDataBHigh;
      if (e.crm == pakr_pkg::CrmDataB && e.op2 == pakr_pkg::Op2BKeyHi) begin
         idx = pakr_pkg::IdxDataBHigh;
      end else if (e.crm == pakr_pkg::CrmDataB && e.op2 == pakr_pkg::Op2BKeyLo) begin
         idx = pakr_pkg::IdxDataBLow;
      end else if (e.crm == pakr_pkg::CrmGenericA && e.op2 == pakr_pkg::Op2AKeyHi) begin
         idx = pakr_pkg::IdxGenericAHigh;
      end else if (e.crm == pakr_pkg::CrmGenericA && e.op2 == pakr_pkg::Op2AKeyLo) begin
         idx = pakr_pkg::IdxGenericALow;
      end else if (e.crm == pakr_pkg::CrmInstrA && e.op2 == pakr_pkg::Op2AKeyHi) begin
         idx = pakr_pkg::IdxInstrAHigh;
      end else if (e.crm == pakr_pkg::CrmInstrA && e.op2 == pakr_pkg::Op2AKeyLo) begin
         idx = pakr_pkg::IdxInstrALow;
      end else begin
         hit = 1'b0;
      end
      return {hit, idx};
   endfunction

   logic [3:0] dec;
   logic allowed;
   assign dec = decode(req.enc);
   // Levels 1 to 3 share one path; unreachable levels never present requests
   assign allowed = FeatureEn && dec[3] && (req.excLevel != pakr_pkg::ElUser);

   always_comb begin
      state_nxt = state_r;
      state_nxt.rsp.done = req.valid;
      state_nxt.rsp.undef = req.valid && !allowed;
      state_nxt.rsp.rdata = '0;
      if (req.valid && allowed) begin
         if (req.isWrite) begin
            state_nxt.keys[dec[2:0]] = req.wdata;
         end else begin
            state_nxt.rsp.rdata = state_r.keys[dec[2:0]];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r.rsp <= '0;
         state_r.keys <= state_nxt.keys;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rsp = state_r.rsp;

   a_user_denied: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && req.excLevel == pakr_pkg::ElUser |=> rsp.done && rsp.undef)
      else $error("level 0 key access was not refused");
   a_known_granted: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && FeatureEn && dec[3] && req.excLevel != pakr_pkg::ElUser |=> !rsp.undef)
      else $error("permitted key access was refused");
   a_foreign_undef: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && !dec[3] |=> rsp.undef)
      else $error("foreign encoding was accepted");
   a_write_readback: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && req.isWrite && allowed ##1 req.valid && !req.isWrite && allowed &&
      dec == $past(dec) |=> rsp.rdata == $past(req.wdata, 2))
      else $error("read did not return last written key");
   a_done_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid |=> rsp.done)
      else $error("request got no answer");
   a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      !req.valid |=> !rsp.done && !rsp.undef)
      else $error("answer without request");
   a_dbh_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmDataB, pakr_pkg::Op2BKeyHi} |-> dec == 4'h8)
      else $error("data key B high misdecoded");
   a_ial_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmInstrA, pakr_pkg::Op2AKeyLo} |-> dec == 4'hd)
      else $error("instruction key A low misdecoded");

   // Remaining slot decodes
   a_dbl_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmDataB, pakr_pkg::Op2BKeyLo} |-> dec == 4'h9)
      else $error("data key B low misdecoded");

   a_gah_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmGenericA, pakr_pkg::Op2AKeyHi} |-> dec == 4'ha)
      else $error("generic key A high misdecoded");

   a_gal_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmGenericA, pakr_pkg::Op2AKeyLo} |-> dec == 4'hb)
      else $error("generic key A low misdecoded");

   a_iah_slot: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc == {pakr_pkg::Op0Sys, pakr_pkg::Op1Key, pakr_pkg::CrnKey,
                  pakr_pkg::CrmInstrA, pakr_pkg::Op2AKeyHi} |-> dec == 4'hc)
      else $error("instruction key A high misdecoded");

   // Foreign fields never hit a slot
   a_op0_foreign: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc.op0 != pakr_pkg::Op0Sys |-> !dec[3])
      else $error("foreign op0 hit a key slot");

   a_op1_foreign: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc.op1 != pakr_pkg::Op1Key |-> !dec[3])
      else $error("foreign op1 hit a key slot");

   a_crn_foreign: assert property (@(posedge clk) disable iff (sys_rst)
      req.enc.crn != pakr_pkg::CrnKey |-> !dec[3])
      else $error("foreign crn hit a key slot");

   // Request kinds as seen at the taking edge
   sequence s_grant_write;
      req.valid && req.isWrite && allowed;
   endsequence

   sequence s_grant_read;
      req.valid && !req.isWrite && allowed;
   endsequence

   sequence s_refused;
      req.valid && !allowed;
   endsequence

   a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
      s_grant_write |=> state_r.keys[$past(dec[2:0])] == $past(req.wdata))
      else $error("granted write did not land");

   a_write_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      s_grant_write |=> rsp.done && !rsp.undef && rsp.rdata == '0)
      else $error("granted write answered wrongly");

   a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
      s_grant_read |=> rsp.done && rsp.rdata == $past(state_r.keys[dec[2:0]]))
      else $error("granted read returned wrong data");

   a_read_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      s_grant_read |=> state_r.keys == $past(state_r.keys))
      else $error("read changed a key");

   a_refused_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      s_refused |=> state_r.keys == $past(state_r.keys))
      else $error("refused access changed a key");

   a_refused_zero: assert property (@(posedge clk) disable iff (sys_rst)
      s_refused |=> rsp.undef && rsp.rdata == '0)
      else $error("refused access returned data");

   a_feature_off: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && !FeatureEn |=> rsp.undef)
      else $error("access granted without the feature");

   a_undef_done: assert property (@(posedge clk) disable iff (sys_rst)
      rsp.undef |-> rsp.done)
      else $error("undefined flag without an answer");

   a_idle_rdata: assert property (@(posedge clk) disable iff (sys_rst)
      !req.valid |=> rsp.rdata == '0)
      else $error("read data without request");

   // Each privileged level 1 to 3 reaches the bank through the one shared path
   a_level1_open: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && FeatureEn && dec[3] && req.excLevel == 2'h1 |=> !rsp.undef)
      else $error("level 1 access refused");

   a_level2_open: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && FeatureEn && dec[3] && req.excLevel == 2'h2 |=> !rsp.undef)
      else $error("level 2 access refused");

   a_level3_open: assert property (@(posedge clk) disable iff (sys_rst)
      req.valid && FeatureEn && dec[3] && req.excLevel == 2'h3 |=> !rsp.undef)
      else $error("level 3 access refused");

   // Reset silences the answer path
   a_reset_quiet: assert property (@(posedge clk)
      sys_rst |=> !rsp.done && !rsp.undef && rsp.rdata == '0)
      else $error("answer during reset");

   a_write_other: assert property (@(posedge clk) disable iff (sys_rst)
      s_grant_write ##1 s_grant_read ##0 (dec[2:0] != $past(dec[2:0])) |=>
      rsp.rdata == $past(state_r.keys[dec[2:0]]))
      else $error("write disturbed another key");
endmodule

//--- dv/pakr_key_regs_tb.sv
// Self-checking bench for the key register bank
`timescale 1ns/100ps
module pakr_key_regs_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   pakr_pkg::pakr_req_t req = '0;
   pakr_pkg::pakr_rsp_t rsp, rspOff;
   logic [15:0] lfsr = 16'h0041;
   logic [63:0] mdl [7];
   pakr_pkg::pakr_enc_t encTab [6];
   int err_total = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   pakr_key_regs dut_u (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));
   pakr_key_regs #(.FeatureEn(1'b0)) dut_off_u (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rsp(rspOff));
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic int idxOf(input pakr_pkg::pakr_enc_t e);
      for (int i = 0; i < 6; i++) if (encTab[i] === e) return i;
      return 6;
   endfunction
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask
   // One request, answer checked the cycle after it is taken
   task automatic access(input logic wr, input logic [1:0] el, input pakr_pkg::pakr_enc_t e,
      input logic [63:0] wd);
      int k;
      logic und;
      k = idxOf(e);
      und = (el == 2'h0) || (k == 6);
      @(posedge clk);
      req <= '{valid: 1'b1, isWrite: wr, excLevel: el, enc: e, wdata: wd};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      chk("done", 64'(rsp.done), 64'h1);
      chk("rdata off", rspOff.rdata, 64'h0);
      chk("undef", 64'(rsp.undef), 64'(und));
      chk("rdata", rsp.rdata, (!wr && !und) ? mdl[k] : 64'h0);
      chk("undef off", 64'(rspOff.undef), 64'h1);
      if (wr && !und) mdl[k] = wd;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial begin
      logic [2:0] k;
      encTab = '{{2'h3, 3'h0, 4'h2, 4'h2, 3'h3}, {2'h3, 3'h0, 4'h2, 4'h2, 3'h2},
         {2'h3, 3'h0, 4'h2, 4'h3, 3'h1}, {2'h3, 3'h0, 4'h2, 4'h3, 3'h0},
         {2'h3, 3'h0, 4'h2, 4'h1, 3'h1}, {2'h3, 3'h0, 4'h2, 4'h1, 3'h0}};
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) access(1'b1, 2'(i % 3) + 2'h1, encTab[i],
         {rnd(), rnd(), rnd(), rnd()});
      for (int i = 0; i < 6; i++) access(1'b0, 2'h0, encTab[i], 64'h0);
      access(1'b1, 2'h0, encTab[0], ~mdl[0]);
      access(1'b1, 2'h1, {2'h3, 3'h0, 4'h2, 4'h2, 3'h1}, 64'h0);
      for (int n = 0; n < 300; n++) begin
         k = 3'(rnd() % 6);
         access(rnd() % 2 == 0, 2'(rnd()), rnd() % 4 == 0 ? pakr_pkg::pakr_enc_t'(rnd()) :
            encTab[k], {rnd(), rnd(), rnd(), rnd()});
      end
      @(posedge clk);
      req.valid <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("done in reset", 64'(rsp.done), 64'h0);
      chk("undef in reset", 64'(rsp.undef), 64'h0);
      @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) access(1'b0, 2'h3, encTab[i], 64'h0);
      end_of_test();
   end
endmodule
